/* hdl/usf_pkg.sv */
// Shared constants, register map and carrier types for the serial status block
package usf_pkg;
   // Register byte addresses on the APB
   localparam logic [11:0] A_DATA = 12'h000;
   localparam logic [11:0] A_RSR = 12'h004;
   localparam logic [11:0] A_FLAGS = 12'h018;
   localparam logic [11:0] A_LCR = 12'h02C;
   localparam logic [11:0] A_CTRL = 12'h030;
   // Line control field positions
   localparam int LCR_PEN = 1;
   localparam int LCR_EPS = 2;
   localparam int LCR_STP2 = 3;
   localparam int LCR_FEN = 4;
   localparam int LCR_WLEN_LO = 5;
   localparam int LCR_SPS = 7;
   localparam logic [7:0] LCR_RESET = 8'h00;
   localparam int CTRL_EN = 0;
   // Flag register bit positions
   localparam int FL_TX_EMPTY_FLAG = 7;
   localparam int FL_RX_FULL_FLAG = 6;
   localparam int FL_TX_FULL_FLAG = 5;
   localparam int FL_RX_EMPTY_FLAG = 4;
   localparam int FL_BUSY = 3;
   // Receive status bit positions
   localparam int RS_FE = 0;
   localparam int RS_PE = 1;
   localparam int RS_BE = 2;
   localparam int RS_OE = 3;
   // Timing and depth
   localparam int BIT_CYC = 16;
   localparam logic [7:0] BIT_LAST = 8'(BIT_CYC - 1);
   localparam logic [7:0] HALF_LAST = 8'(BIT_CYC / 2 - 1);
   localparam logic [3:0] WLEN_BASE = 4'h5;
   localparam int FIFO_DEPTH = 16;
   localparam int PTR_W = 4;
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] FIFO_FULL_CNT = 5'h10;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } usf_apb_req_s;

   typedef struct packed {
      logic oe;
      logic be;
      logic pe;
      logic fe;
      logic [7:0] data;
   } usf_rx_entry_s;

   typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP, S_STOP2, S_BRK} usf_ser_e;
endpackage

/* hdl/usf_fifo.sv */
// Circular FIFO that can shrink to a single holding register
`timescale 1ns/1ps
module usf_fifo
   import usf_pkg::*;
#(
   parameter int W = 8
) (
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire logic push_i,
   input wire logic [W-1:0] wdata_i,
   input wire logic pop_i,
   input wire logic depth1_i,
   output logic [W-1:0] rdata_o,
   output logic full_o,
   output logic empty_o
);
   typedef struct packed {
      logic [FIFO_DEPTH-1:0][W-1:0] mem;
      logic [PTR_W-1:0] wp;
      logic [PTR_W-1:0] rp;
      logic [CNT_W-1:0] cnt;
   } usf_fifo_state_s;

   usf_fifo_state_s st;
   usf_fifo_state_s next_st;
   logic do_push;
   logic do_pop;

   // Single-entry mode only changes when full is seen
   assign full_o = depth1_i ? (st.cnt != '0) : (st.cnt == FIFO_FULL_CNT);
   assign empty_o = (st.cnt == '0);
   assign rdata_o = st.mem[st.rp];
   assign do_push = push_i && !full_o;
   assign do_pop = pop_i && !empty_o;

   always_comb begin
      next_st = st;
      if (do_push) begin
         next_st.mem[st.wp] = wdata_i;
         next_st.wp = st.wp + 1'b1;
      end
      if (do_pop) begin
         next_st.rp = st.rp + 1'b1;
      end
      if (do_push && !do_pop) begin
         next_st.cnt = st.cnt + 1'b1;
      end else if (do_pop && !do_push) begin
         next_st.cnt = st.cnt - 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end
endmodule // usf_fifo

/* hdl/usf_top.sv */
// Serial port receive error flags, error clear and line flag register on APB
// What this block does
// - Overrun flag sets when a character arrives with receive FIFO full; stays until clear.
// - On overrun the FIFO keeps its entries and takes no new one.
// - Break flag sets when the line stays low a whole frame.
// - A break loads exactly one all-zero character into the receive FIFO.
// - After break, wait for line high and a new start bit.
// - In FIFO mode errors travel with the character at the FIFO head.
// - Parity error sets when received parity disagrees with even/stick parity setting, except in a break (whole frame low).
// - Framing error sets when the stop bit is sampled low, except in a break (whole frame low), which stores the break bit and no framing or parity error.
// - Any write to error clear clears framing, parity, break and overrun.
// - After reset tx/rx full and busy read 0, tx/rx empty read 1.
// - Flag bit 7 shows transmit holding register or FIFO empty.
// - Flag bit 6 shows receive holding register or FIFO full.
// - Flag bit 5 shows transmit holding register or FIFO full.
// - Flag bit 4 shows receive holding register or FIFO empty.
// - Busy stays 1 until the last stop bit has left the shifter.
// - Busy is 1 whenever the transmit FIFO holds data, enabled or not.
// - Each received byte is stored with its four status bits as 12 bits.
// - Receive status gathers the errors of every entry read, sticky until cleared; overrun shows at once.
// - FIFO enable bit 4 selects FIFOs; else single-entry holding registers.
`timescale 1ns/1ps
module usf_top
   import usf_pkg::*;
(
   input wire logic mclk_i,
   input wire logic nrst_i,
   input wire usf_apb_req_s apb_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic rx_i,
   output logic tx_o
);
   typedef struct packed {
      usf_ser_e rx_st;
      logic [7:0] rx_cnt;
      logic [3:0] rx_bits;
      logic [7:0] rx_shift;
      logic rx_perr;
      logic rx_zero;
      logic ovr_pend;
      usf_ser_e tx_st;
      logic [7:0] tx_cnt;
      logic [3:0] tx_bits;
      logic [7:0] tx_shift;
      logic tx_line;
      logic [7:0] lcr;
      logic en;
      logic [3:0] rsr;
      logic [31:0] prdata;
      logic pslverr;
   } usf_state_s;

   usf_state_s st;
   usf_state_s next_st;

   logic fifo_enable_bit;
   logic pen;
   logic [3:0] wlen;
   logic setup;
   logic access;
   logic rx_push;
   usf_rx_entry_s rx_word;
   usf_rx_entry_s rx_head;
   logic rx_pop;
   logic rx_full;
   logic rx_empty;
   logic tx_push;
   logic tx_pop;
   logic [7:0] tx_head;
   logic tx_full;
   logic tx_empty;
   logic busy;
   logic overrun;
   logic brk_push;
   logic [7:0] flags;

   assign fifo_enable_bit = st.lcr[LCR_FEN];
   assign pen = st.lcr[LCR_PEN];
   assign wlen = WLEN_BASE + {2'b00, st.lcr[LCR_WLEN_LO+1:LCR_WLEN_LO]};
   assign setup = apb_i.psel && !apb_i.penable;
   assign access = apb_i.psel && apb_i.penable;
   assign pready_o = 1'b1;
   assign prdata_o = st.prdata;
   assign pslverr_o = access && st.pslverr;
   assign tx_o = st.tx_line;

   // Expected parity bit for the current character
   function automatic logic par_bit(input logic [7:0] d, input logic [7:0] lcr);
      logic r;
      r = 1'b0;
      if (lcr[LCR_SPS]) begin
         r = !lcr[LCR_EPS];
      end else begin
         r = lcr[LCR_EPS] ? ^d : ~^d;
      end
      return r;
   endfunction

   // 12-bit entries; a single-entry holding register in character mode
   usf_fifo #(.W(12)) rx_fifo (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .push_i(rx_push),
      .wdata_i(rx_word),
      .pop_i(rx_pop),
      .depth1_i(!fifo_enable_bit),
      .rdata_o(rx_head),
      .full_o(rx_full),
      .empty_o(rx_empty)
   );

   usf_fifo #(.W(8)) tx_fifo (
      .mclk_i(mclk_i),
      .nrst_i(nrst_i),
      .push_i(tx_push),
      .wdata_i(apb_i.pwdata[7:0]),
      .pop_i(tx_pop),
      .depth1_i(!fifo_enable_bit),
      .rdata_o(tx_head),
      .full_o(tx_full),
      .empty_o(tx_empty)
   );

   // Busy covers queued data even with the port disabled
   assign busy = !tx_empty || (st.tx_st != S_IDLE);

   always_comb begin
      flags = 8'h00;
      flags[FL_TX_EMPTY_FLAG] = tx_empty;
      flags[FL_RX_FULL_FLAG] = rx_full;
      flags[FL_TX_FULL_FLAG] = tx_full;
      flags[FL_RX_EMPTY_FLAG] = rx_empty;
      flags[FL_BUSY] = busy;
   end

   always_comb begin
      next_st = st;
      rx_push = 1'b0;
      rx_word = '0;
      rx_pop = 1'b0;
      tx_push = 1'b0;
      tx_pop = 1'b0;
      brk_push = 1'b0;

      // Receiver
      next_st.rx_cnt = st.rx_cnt + 8'h01;
      unique case (st.rx_st)
         S_IDLE: begin
            next_st.rx_cnt = 8'h00;
            if (st.en && !rx_i) begin
               next_st.rx_st = S_START;
               next_st.rx_shift = 8'h00;
               next_st.rx_bits = 4'h0;
            end
         end
         S_START: begin
            if (st.rx_cnt == HALF_LAST) begin
               next_st.rx_cnt = 8'h00;
               next_st.rx_zero = 1'b1;
               next_st.rx_st = rx_i ? S_IDLE : S_DATA;
            end
         end
         S_DATA: begin
            if (st.rx_cnt == BIT_LAST) begin
               next_st.rx_cnt = 8'h00;
               next_st.rx_shift[st.rx_bits[2:0]] = rx_i;
               next_st.rx_zero = st.rx_zero && !rx_i;
               next_st.rx_bits = st.rx_bits + 4'h1;
               if (st.rx_bits + 4'h1 == wlen) begin
                  next_st.rx_perr = 1'b0;
                  next_st.rx_st = pen ? S_PAR : S_STOP;
               end
            end
         end
         S_PAR: begin
            if (st.rx_cnt == BIT_LAST) begin
               next_st.rx_cnt = 8'h00;
               next_st.rx_zero = st.rx_zero && !rx_i;
               next_st.rx_perr = (rx_i != par_bit(st.rx_shift, st.lcr));
               next_st.rx_st = S_STOP;
            end
         end
         S_STOP: begin
            if (st.rx_cnt == BIT_LAST) begin
               next_st.rx_cnt = 8'h00;
               rx_push = 1'b1;
               rx_word.oe = st.ovr_pend;
               if (st.rx_zero && !rx_i) begin
                  // Whole frame low: one zero character, then wait for mark
                  brk_push = 1'b1;
                  rx_word.be = 1'b1;
                  next_st.rx_st = S_BRK;
               end else begin
                  rx_word.data = st.rx_shift;
                  rx_word.pe = st.rx_perr;
                  rx_word.fe = !rx_i;
                  next_st.rx_st = S_IDLE;
               end
            end
         end
         S_BRK: begin
            next_st.rx_cnt = 8'h00;
            if (rx_i) begin
               next_st.rx_st = S_IDLE;
            end
         end
         default: begin
            next_st.rx_st = S_IDLE;
         end
      endcase

      // Overrun: flag at once, FIFO untouched, mark the next stored entry
      if (overrun) begin
         next_st.ovr_pend = 1'b1;
      end else if (rx_push) begin
         next_st.ovr_pend = 1'b0;
      end

      // Transmitter
      next_st.tx_cnt = st.tx_cnt + 8'h01;
      unique case (st.tx_st)
         S_IDLE, S_BRK: begin
            next_st.tx_cnt = 8'h00;
            next_st.tx_line = 1'b1;
            if (st.en && !tx_empty) begin
               tx_pop = 1'b1;
               // Bits above the word length must not reach the parity
               next_st.tx_shift = tx_head & (8'hFF >> (4'h8 - wlen));
               next_st.tx_bits = 4'h0;
               next_st.tx_line = 1'b0;
               next_st.tx_st = S_START;
            end
         end
         S_START, S_DATA: begin
            if (st.tx_cnt == BIT_LAST) begin
               next_st.tx_cnt = 8'h00;
               if (st.tx_st == S_DATA && st.tx_bits == wlen) begin
                  next_st.tx_line = pen ? par_bit(st.tx_shift, st.lcr) : 1'b1;
                  next_st.tx_st = pen ? S_PAR : S_STOP;
               end else begin
                  next_st.tx_line = st.tx_shift[st.tx_bits[2:0]];
                  next_st.tx_bits = st.tx_bits + 4'h1;
                  next_st.tx_st = S_DATA;
               end
            end
         end
         S_PAR: begin
            if (st.tx_cnt == BIT_LAST) begin
               next_st.tx_cnt = 8'h00;
               next_st.tx_line = 1'b1;
               next_st.tx_st = S_STOP;
            end
         end
         S_STOP: begin
            if (st.tx_cnt == BIT_LAST) begin
               next_st.tx_cnt = 8'h00;
               next_st.tx_st = st.lcr[LCR_STP2] ? S_STOP2 : S_IDLE;
            end
         end
         S_STOP2: begin
            if (st.tx_cnt == BIT_LAST) begin
               next_st.tx_cnt = 8'h00;
               next_st.tx_st = S_IDLE;
            end
         end
         default: begin
            next_st.tx_st = S_IDLE;
         end
      endcase

      // APB: read data captured in setup, side effects at access edge
      next_st.pslverr = 1'b0;
      if (setup) begin
         next_st.prdata = 32'h0000_0000;
         unique case (apb_i.paddr)
            A_DATA: next_st.prdata = rx_empty ? 32'h0000_0000 : {20'h00000, rx_head};
            A_RSR: next_st.prdata = {28'h0000000, st.rsr};
            A_FLAGS: next_st.prdata = {24'h000000, flags};
            A_LCR: next_st.prdata = {24'h000000, st.lcr};
            A_CTRL: next_st.prdata = {31'h00000000, st.en};
            default: next_st.pslverr = 1'b1;
         endcase
      end else begin
         next_st.pslverr = st.pslverr;
      end
      if (access) begin
         if (apb_i.pwrite) begin
            unique case (apb_i.paddr)
               A_DATA: tx_push = 1'b1;
               A_RSR: next_st.rsr = 4'h0;
               A_LCR: next_st.lcr = apb_i.pwdata[7:0];
               A_CTRL: next_st.en = apb_i.pwdata[CTRL_EN];
               default: ;
            endcase
         end else if (apb_i.paddr == A_DATA && !rx_empty) begin
            rx_pop = 1'b1;
            // Status follows the entry just read, sticky until cleared
            next_st.rsr[RS_FE] = next_st.rsr[RS_FE] | rx_head.fe;
            next_st.rsr[RS_PE] = next_st.rsr[RS_PE] | rx_head.pe;
            next_st.rsr[RS_BE] = next_st.rsr[RS_BE] | rx_head.be;
         end
      end
      // Set wins over a same-cycle clear
      if (overrun) begin
         next_st.rsr[RS_OE] = 1'b1;
      end
      if (rx_pop) begin
         next_st.rsr[RS_FE] = next_st.rsr[RS_FE] | rx_head.fe;
         next_st.rsr[RS_PE] = next_st.rsr[RS_PE] | rx_head.pe;
         next_st.rsr[RS_BE] = next_st.rsr[RS_BE] | rx_head.be;
      end
   end

   // Push while full, even with a same-cycle pop: the 12-bit entry is dropped
   assign overrun = rx_push && rx_full;

   always_ff @(posedge mclk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st <= '{rx_st: S_IDLE, tx_st: S_IDLE, tx_line: 1'b1, lcr: LCR_RESET, default: '0};
      end else begin
         st <= next_st;
      end
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!nrst_i);

   sequence seq_brk_stop;
      st.rx_st == S_STOP && st.rx_cnt == BIT_LAST && st.rx_zero && !rx_i;
   endsequence

   chk_ovr_sets: assert property (overrun |=> st.rsr[RS_OE])
      else $error("overrun flag not set");
   chk_ovr_keep: assert property (overrun && !rx_pop |=> rx_full && $stable(rx_head))
      else $error("fifo changed on overrun");
   chk_brk_zero: assert property (seq_brk_stop |-> brk_push && rx_word.data == 8'h00 && rx_word.be)
      else $error("break not stored as zero");
   chk_brk_hold: assert property (seq_brk_stop ##1 !rx_i |-> st.rx_st == S_BRK ##1 !rx_push)
      else $error("receiver left break wait early");
   chk_err_clear: assert property (access && apb_i.pwrite && apb_i.paddr == A_RSR && !overrun
      |=> st.rsr == 4'h0)
      else $error("error clear ignored");
   chk_busy_fifo: assert property (!tx_empty |-> flags[FL_BUSY])
      else $error("busy low with queued data");
   chk_busy_stop: assert property (st.tx_st == S_STOP && st.tx_cnt != BIT_LAST |=> flags[FL_BUSY])
      else $error("busy dropped before stop bit end");
   chk_char_full: assert property (!fifo_enable_bit && !rx_empty |-> flags[FL_RX_FULL_FLAG] && !flags[FL_RX_EMPTY_FLAG])
      else $error("holding register full flag wrong");
   chk_frame_err: assert property (st.rx_st == S_STOP && st.rx_cnt == BIT_LAST && !st.rx_zero
      |-> rx_push && rx_word.fe == !rx_i)
      else $error("framing bit wrong");
   chk_flag_resv: assert property (setup && apb_i.paddr == A_FLAGS
      |=> st.prdata[31:8] == 24'h000000 && st.prdata[2:0] == 3'h0)
      else $error("reserved flag bits not zero");
endmodule // usf_top

/* testbench/usf_peer.sv */
// Behavioural far-end serial peer: sends frames and breaks, decodes transmitted bytes
`timescale 1ns/1ps
module usf_peer
   import usf_pkg::*;
(
   input wire logic mclk_i,
   output logic rx_o,
   input wire logic tx_i
);
   logic [7:0] tx_byte = 8'h00;
   int tx_cnt = 0;
   logic [7:0] sh = 8'h00;

   initial rx_o = 1'b1;

   task automatic bit_out(input logic v);
      rx_o <= v;
      repeat (BIT_CYC) @(posedge mclk_i);
   endtask

   // Parity and stop levels come from the caller, so bad frames are only sent on request
   task automatic send(input logic [7:0] d, input int nb, input logic pen, input logic par,
                       input logic stop);
      bit_out(1'b0);
      for (int i = 0; i < nb; i++) bit_out(d[i]);
      if (pen) bit_out(par);
      bit_out(stop);
      rx_o <= 1'b1;
   endtask

   task automatic brk(input int n);
      rx_o <= 1'b0;
      repeat (n) @(posedge mclk_i);
      rx_o <= 1'b1;
      repeat (BIT_CYC) @(posedge mclk_i);
   endtask

   // Mid-bit sampling; only 8-bit frames without parity are decoded
   initial begin
      forever begin
         @(negedge tx_i);
         repeat (BIT_CYC / 2) @(posedge mclk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge mclk_i);
            sh = {tx_i, sh[7:1]};
         end
         tx_byte = sh;
         tx_cnt++;
         repeat (BIT_CYC) @(posedge mclk_i);
      end
   end
endmodule // usf_peer

/* testbench/tb_uart_rx_status_and_flags.sv */
// Self-checking testbench for the receive error flags, error clear and line flags
`timescale 1ns/1ps
module tb_uart_rx_status_and_flags
   import usf_pkg::*;
;
   typedef struct packed {
      logic [7:0] lcr;
      logic [7:0] d;
      logic par;
      logic stop;
      logic [11:0] exp;
   } usf_row_s;
   logic mclk_i = 1'b0;
   logic nrst_i = 1'b0;
   usf_apb_req_s apb = '0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, rx_i, tx_o, err;
   logic [31:0] rdv;
   int n_errors = 0;
   int compares = 0;
   int k, n, tx0;
   usf_row_s rows [12] = '{
      '{8'h60, 8'hA5, 1'b0, 1'b1, 12'h0A5}, '{8'h66, 8'h03, 1'b0, 1'b1, 12'h003},
      '{8'h66, 8'h07, 1'b0, 1'b1, 12'h207}, '{8'h62, 8'h07, 1'b0, 1'b1, 12'h007},
      '{8'h62, 8'h03, 1'b0, 1'b1, 12'h203}, '{8'hE6, 8'h01, 1'b1, 1'b1, 12'h201},
      '{8'hE6, 8'h02, 1'b0, 1'b1, 12'h002}, '{8'hE2, 8'h01, 1'b1, 1'b1, 12'h001},
      '{8'hE2, 8'h01, 1'b0, 1'b1, 12'h201}, '{8'h60, 8'h5A, 1'b1, 1'b0, 12'h15A},
      '{8'h00, 8'hFF, 1'b0, 1'b1, 12'h01F}, '{8'h40, 8'hFF, 1'b0, 1'b1, 12'h07F}};

   always #2 mclk_i = ~mclk_i;

   usf_top usf_top_inst (.mclk_i(mclk_i), .nrst_i(nrst_i), .apb_i(apb), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .rx_i(rx_i), .tx_o(tx_o));
   usf_peer usf_peer_inst (.mclk_i(mclk_i), .rx_o(rx_i), .tx_i(tx_o));

   task automatic results;
      $display("Comparisons %0d, mismatches %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic give_up;
      n_errors++;
      $display("CHECK FAILED at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      results();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Request held until pready is seen high at a rising edge
   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int w;
      @(posedge mclk_i);
      apb <= '{1'b1, 1'b0, wr, a, wd};
      @(posedge mclk_i);
      apb.penable <= 1'b1;
      w = 0;
      @(posedge mclk_i);
      while (pready_o !== 1'b1) begin
         w++;
         if (w > 16) give_up();
         @(posedge mclk_i);
      end
      rdv = prdata_o;
      err = pslverr_o;
      apb <= '0;
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask

   task automatic frame(input logic [7:0] lcr, input logic [7:0] d, input logic par,
                        input logic stop);
      usf_peer_inst.send(d, 5 + int'(lcr[6:5]), lcr[1], par, stop);
      repeat (4) @(posedge mclk_i);
   endtask

   initial begin
      repeat (12) @(posedge mclk_i);
      nrst_i <= 1'b1;
      rdchk(A_FLAGS, 32'h90);
      rdchk(A_RSR, 32'h0);
      xfer(1'b1, A_CTRL, 32'h1);
      foreach (rows[i]) begin
         xfer(1'b1, A_LCR, {24'h0, rows[i].lcr});
         frame(rows[i].lcr, rows[i].d, rows[i].par, rows[i].stop);
         rdchk(A_FLAGS, 32'hC0);
         rdchk(A_DATA, {20'h0, rows[i].exp});
         rdchk(A_RSR, {28'h0, rows[i].exp[11:8]});
         xfer(1'b1, A_RSR, 32'(i * 37));
         rdchk(A_RSR, 32'h0);
         rdchk(A_FLAGS, 32'h90);
      end
      // Line held low for far longer than one frame
      xfer(1'b1, A_LCR, 32'h70);
      usf_peer_inst.brk(400);
      rdchk(A_FLAGS, 32'h80);
      rdchk(A_DATA, 32'h400);
      rdchk(A_FLAGS, 32'h90);
      rdchk(A_RSR, 32'h4);
      xfer(1'b1, A_RSR, 32'h0);
      frame(8'h70, 8'h33, 1'b0, 1'b1);
      rdchk(A_DATA, 32'h33);
      // Fill the receive FIFO, then one too many; the all-low first frame is a break
      for (int i = 0; i < 17; i++) begin
         frame(8'h70, 8'(i), 1'b0, i != 0);
         if (i == 15) rdchk(A_FLAGS, 32'hC0);
      end
      rdchk(A_RSR, 32'h8);
      for (int i = 0; i < 16; i++) rdchk(A_DATA, (i == 0) ? 32'h400 : 32'(i));
      rdchk(A_FLAGS, 32'h90);
      rdchk(A_RSR, 32'hC);
      xfer(1'b1, A_RSR, 32'hFF);
      rdchk(A_RSR, 32'h0);
      // Transmit side: load while disabled, then let it drain
      xfer(1'b1, A_CTRL, 32'h0);
      for (int m = 0; m < 2; m++) begin
         n = m ? 16 : 1;
         xfer(1'b1, A_LCR, m ? 32'h78 : 32'h60);
         tx0 = usf_peer_inst.tx_cnt;
         for (int j = 0; j <= n; j++) xfer(1'b1, A_DATA, 32'(8'h40 + j));
         rdchk(A_FLAGS, 32'h38);
         xfer(1'b1, A_CTRL, 32'h1);
         repeat (150) @(posedge mclk_i);
         rdchk(A_FLAGS, m ? 32'h18 : 32'h98);
         k = 0;
         while (rdv[FL_BUSY] !== 1'b0 && k < 2000) begin
            xfer(1'b0, A_FLAGS, 32'h0);
            k++;
         end
         if (k == 2000) give_up();
         chk(rdv, 32'h90);
         chk(32'(usf_peer_inst.tx_cnt - tx0), 32'(n));
         chk({24'h0, usf_peer_inst.tx_byte}, 32'(8'h40 + n - 1));
         xfer(1'b1, A_CTRL, 32'h0);
      end
      xfer(1'b1, A_FLAGS, 32'hFFFFFFFF);
      rdchk(A_FLAGS, 32'h90);
      rdchk(12'h100, 32'h0);
      chk({31'h0, err}, 32'h1);
      // Reset in mid-run with data and status held
      xfer(1'b1, A_CTRL, 32'h1);
      frame(8'h70, 8'h5A, 1'b0, 1'b0);
      xfer(1'b0, A_DATA, 32'h0);
      frame(8'h70, 8'h66, 1'b0, 1'b1);
      nrst_i <= 1'b0;
      repeat (3) @(posedge mclk_i);
      nrst_i <= 1'b1;
      rdchk(A_FLAGS, 32'h90);
      rdchk(A_RSR, 32'h0);
      results();
   end
endmodule // tb_uart_rx_status_and_flags
